// File: verilog/dma_channel_request_assign.v
// channel request, requester assignment, item counting and completion signalling
//
// Our own choices: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "dma_assign_regs.vh"
// Functional notes
// R01 - software can start any channel's transfer without a peripheral request
// R02 - software channel completion pulses the dedicated interrupt line
// R03 - peripheral channel completion pulses that peripheral's own interrupt line
// R04 - scatter-gather takes a task list start address and task count
// R05 - a flag picks peripheral or memory scatter-gather variant
// R06 - default-assign bitmask returns any set of channels to default requester
// R07 - secondary-assign bitmask moves any set of channels to secondary requester
// R08 - with secondary selected, default requester is not served on that channel
// R09 - transfer size counts items of 8, 16 or 32 bits
// R10 - size read gives remaining items, zero once finished
// R11 - completion clears the channel enable; further requests ignored
// R12 - completion writes stopped mode into the structure in use
// R13 - after reset every channel uses its default requester
module dma_channel_request_assign
(
    // clock and reset
    input  wire                  CLK,
    input  wire                  ARST_N,
    input  wire                  CE,
    // avalon-mm slave
    input  wire [5:0]            AVS_ADDRESS,
    input  wire                  AVS_READ,
    input  wire                  AVS_WRITE,
    input  wire [31:0]           AVS_WRITEDATA,
    input  wire [3:0]            AVS_BYTEENABLE,
    output reg  [31:0]           AVS_READDATA,
    output wire                  AVS_WAITREQUEST,
    // peripheral requests
    input  wire [31:0]           DEF_REQ,
    input  wire [31:0]           SEC_REQ,
    // completion interrupts
    output reg  [31:0]           DEF_DONE_IRQ,
    output reg  [31:0]           SEC_DONE_IRQ,
    output reg                   SW_DONE_IRQ,
    // data item strobe, one pulse per item moved, then scatter-gather task outputs
    output reg                   ITEM_VALID,
    output reg  [4:0]            ITEM_CHANNEL,
    output reg  [1:0]            ITEM_WIDTH,
    output reg  [31:0]           TASK_LIST_ADDR,
    output reg  [9:0]            TASK_COUNT_OUT,
    output reg                   SG_PERIPH_OUT
);
    localparam ST_IDLE  = 2'h0;
    localparam ST_READ  = 2'h1;
    localparam ST_WRITE = 2'h2;
    localparam ST_ANS   = 2'h3;

    reg  [1:0]  state_reg;
    reg  [31:0] enable_reg;
    reg  [31:0] sw_req_reg;
    reg  [31:0] sec_sel_reg;
    reg  [31:0] alt_active_reg;
    reg  [5:0]  struct_sel_reg;
    reg  [1:0]  item_w_reg;
    reg  [8:0]  sg_cfg_reg;
    reg  [31:0] task_list_reg;
    reg  [9:0]  task_count_reg;
    reg  [31:0] done_stat_reg;
    reg  [4:0]  chan_reg;
    reg         busy_reg;
    reg         bus_ack_reg;
    reg  [2:0]  mode_wr_reg;
    reg  [10:0] size_wr_reg;

    wire [13:0] mem_rd;
    reg         mem_we;
    reg  [5:0]  mem_waddr;
    reg  [13:0] mem_wdata;
    reg  [5:0]  mem_raddr;
    wire [31:0] pending;
    wire        any_pending;
    wire [4:0]  pick;
    wire [31:0] wmask;
    wire        sel_wr;

    // pick lowest pending channel; fixed priority keeps arbitration short
    function [4:0] lowest;
        input [31:0] v;
        integer i;
        begin
            lowest = 5'h00;
            for (i = 31; i >= 0; i = i - 1)
                if (v[i])
                    lowest = i[4:0];
        end
    endfunction

    // byte-enable mask for writes
    function [31:0] be_mask;
        input [3:0] be;
        begin
            be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        end
    endfunction

    assign wmask = be_mask(AVS_BYTEENABLE);
    // R08 default blocked
    // R01 software request
    assign pending = enable_reg & (sw_req_reg | (DEF_REQ & ~sec_sel_reg) | (SEC_REQ & sec_sel_reg));
    assign any_pending = |pending;
    assign pick = lowest(pending);
    assign sel_wr = (state_reg == ST_IDLE) && AVS_WRITE && (AVS_ADDRESS == `OFS_STRUCT_SEL);
    assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~bus_ack_reg;

    struct_mem u_mem
    (
        .clk     (CLK),
        .ce      (CE),
        .wr_en   (mem_we),
        .wr_addr (mem_waddr),
        .wr_data (mem_wdata),
        .rd_addr (mem_raddr),
        .rd_data (mem_rd)
    );

    // memory port steering: bus writes win over the engine, engine idles that cycle
    always @*
    begin
        mem_we    = 1'b0;
        mem_waddr = struct_sel_reg;
        mem_wdata = {mode_wr_reg, size_wr_reg};
        mem_raddr = struct_sel_reg;
        if (state_reg == ST_WRITE && (AVS_ADDRESS == `OFS_MODE || AVS_ADDRESS == `OFS_SIZE))
        begin
            mem_we = 1'b1;
            if (AVS_ADDRESS == `OFS_MODE)
                mem_wdata = {AVS_WRITEDATA[2:0], mem_rd[10:0]};
            else
                // R09 count in items
                mem_wdata = {mem_rd[13:11], AVS_WRITEDATA[10:0]};
        end
        else if (busy_reg)
        begin
            mem_raddr = {alt_active_reg[chan_reg], chan_reg};
            mem_waddr = {alt_active_reg[chan_reg], chan_reg};
            mem_we    = 1'b1;
            if (mem_rd[10:0] <= 11'h001)
                // R12 stopped mode
                // R10 reads zero
                mem_wdata = {`MODE_STOP, 11'h000};
            else
                // R10 remaining items
                mem_wdata = {mem_rd[13:11], mem_rd[10:0] - 11'h001};
        end
        else if (any_pending)
            mem_raddr = {alt_active_reg[pick], pick};
    end

    // bus slave: two wait cycles, the second reads the structure memory, then answer
    always @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            state_reg      <= ST_IDLE;
            bus_ack_reg    <= 1'b0;
            AVS_READDATA   <= 32'h00000000;
            enable_reg     <= 32'h00000000;
            sw_req_reg     <= 32'h00000000;
            // R13 default requester after reset
            sec_sel_reg    <= `ASSIGN_RST;
            alt_active_reg <= 32'h00000000;
            struct_sel_reg <= 6'h00;
            item_w_reg     <= `ITEM_8;
            sg_cfg_reg     <= 9'h000;
            task_list_reg  <= 32'h00000000;
            task_count_reg <= 10'h000;
            done_stat_reg  <= 32'h00000000;
            chan_reg       <= 5'h00;
            busy_reg       <= 1'b0;
            mode_wr_reg    <= `MODE_STOP;
            size_wr_reg    <= 11'h000;
            DEF_DONE_IRQ   <= 32'h00000000;
            SEC_DONE_IRQ   <= 32'h00000000;
            SW_DONE_IRQ    <= 1'b0;
            ITEM_VALID     <= 1'b0;
            ITEM_CHANNEL   <= 5'h00;
            ITEM_WIDTH     <= `ITEM_8;
            TASK_LIST_ADDR <= 32'h00000000;
            TASK_COUNT_OUT <= 10'h000;
            SG_PERIPH_OUT  <= 1'b0;
        end
        else if (CE)
        begin
            bus_ack_reg  <= 1'b0;
            ITEM_VALID   <= 1'b0;
            DEF_DONE_IRQ <= 32'h00000000;
            SEC_DONE_IRQ <= 32'h00000000;
            SW_DONE_IRQ  <= 1'b0;
            // engine: one item per two cycles, read then count down
            if (busy_reg && !(state_reg == ST_WRITE))
            begin
                busy_reg     <= 1'b0;
                ITEM_VALID   <= 1'b1;
                ITEM_CHANNEL <= chan_reg;
                ITEM_WIDTH   <= item_w_reg;
                if (mem_rd[10:0] <= 11'h001)
                begin
                    // R11 auto disable; a software request stands until the whole transfer ends
                    enable_reg[chan_reg]    <= 1'b0;
                    sw_req_reg[chan_reg]    <= 1'b0;
                    done_stat_reg[chan_reg] <= 1'b1;
                    if (chan_reg == `SW_CHANNEL)
                        // R02 dedicated line
                        SW_DONE_IRQ <= 1'b1;
                    else if (sec_sel_reg[chan_reg])
                        // R03 peripheral line
                        SEC_DONE_IRQ[chan_reg] <= 1'b1;
                    else
                        // R03 peripheral line
                        DEF_DONE_IRQ[chan_reg] <= 1'b1;
                end
            end
            else if (!busy_reg && any_pending && state_reg == ST_IDLE && !(AVS_READ || AVS_WRITE))
            begin
                busy_reg <= 1'b1;
                chan_reg <= pick;
            end
            case (state_reg)
                ST_IDLE:
                begin
                    if (AVS_READ && !bus_ack_reg)
                        state_reg <= ST_READ;
                    else if (AVS_WRITE && !bus_ack_reg)
                        state_reg <= ST_WRITE;
                    if (sel_wr)
                        struct_sel_reg <= AVS_WRITEDATA[5:0];
                end
                ST_READ:
                begin
                    state_reg   <= ST_ANS;
                    bus_ack_reg <= 1'b1;
                    case (AVS_ADDRESS)
                        `OFS_CH_ENABLE:   AVS_READDATA <= enable_reg;
                        `OFS_SW_REQ:      AVS_READDATA <= sw_req_reg;
                        `OFS_ASSIGN_STAT: AVS_READDATA <= sec_sel_reg;
                        `OFS_STRUCT_SEL:  AVS_READDATA <= {26'h0000000, struct_sel_reg};
                        `OFS_MODE:        AVS_READDATA <= {29'h00000000, mem_rd[13:11]};
                        `OFS_SIZE:        AVS_READDATA <= {21'h000000, mem_rd[10:0]};
                        `OFS_ITEM_W:      AVS_READDATA <= {30'h00000000, item_w_reg};
                        `OFS_SG_CFG:      AVS_READDATA <= {23'h000000, sg_cfg_reg};
                        `OFS_TASK_LIST:   AVS_READDATA <= task_list_reg;
                        `OFS_TASK_COUNT:  AVS_READDATA <= {22'h000000, task_count_reg};
                        `OFS_DONE_STAT:   AVS_READDATA <= done_stat_reg;
                        default:          AVS_READDATA <= 32'h00000000;
                    endcase
                end
                ST_WRITE:
                begin
                    state_reg   <= ST_ANS;
                    bus_ack_reg <= 1'b1;
                    case (AVS_ADDRESS)
                        `OFS_CH_ENABLE: enable_reg <= (enable_reg & ~wmask) | (AVS_WRITEDATA & wmask);
                        // R01 software request
                        `OFS_SW_REQ:    sw_req_reg <= sw_req_reg | (AVS_WRITEDATA & wmask);
                        // R06 default mask
                        `OFS_DEF_ASSIGN: sec_sel_reg <= sec_sel_reg & ~(AVS_WRITEDATA & wmask);
                        // R07 secondary mask
                        `OFS_SEC_ASSIGN: sec_sel_reg <= sec_sel_reg | (AVS_WRITEDATA & wmask);
                        `OFS_MODE:
                        begin
                            // primary/alternate memory image decides which structure runs
                            alt_active_reg[struct_sel_reg[4:0]] <= struct_sel_reg[`SEL_ALT_BIT];
                        end
                        `OFS_ITEM_W:    item_w_reg <= AVS_WRITEDATA[1:0];
                        // R05 sg variant
                        `OFS_SG_CFG:    sg_cfg_reg <= AVS_WRITEDATA[8:0];
                        // R04 task list
                        `OFS_TASK_LIST:
                        begin
                            task_list_reg  <= AVS_WRITEDATA;
                            TASK_LIST_ADDR <= AVS_WRITEDATA;
                        end
                        // R04 task count
                        `OFS_TASK_COUNT:
                        begin
                            task_count_reg <= AVS_WRITEDATA[9:0];
                            TASK_COUNT_OUT <= AVS_WRITEDATA[9:0];
                            SG_PERIPH_OUT  <= sg_cfg_reg[`SG_PERIPH_BIT];
                        end
                        // write-one-to-clear; the engine is held during the write, so no completion falls in that cycle
                        `OFS_DONE_STAT: done_stat_reg <= done_stat_reg & ~(AVS_WRITEDATA & wmask);
                        default:        state_reg <= ST_ANS;
                    endcase
                end
                ST_ANS:
                begin
                    state_reg <= ST_IDLE;
                end
                default:
                begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// File: verilog/dma_assign_regs.vh
// register offsets, field positions, reset values and encodings for the dma channel request/assign block
`ifndef DMA_ASSIGN_REGS_VH
`define DMA_ASSIGN_REGS_VH
`define NUM_CH            32
`define CH_W              5
`define SW_CHANNEL        5'h1e
// register byte offsets
`define OFS_CH_ENABLE     6'h00
`define OFS_SW_REQ        6'h04
`define OFS_DEF_ASSIGN    6'h08
`define OFS_SEC_ASSIGN    6'h0c
`define OFS_ASSIGN_STAT   6'h10
`define OFS_STRUCT_SEL    6'h14
`define OFS_MODE          6'h18
`define OFS_SIZE          6'h1c
`define OFS_ITEM_W        6'h20
`define OFS_SG_CFG        6'h24
`define OFS_TASK_LIST     6'h28
`define OFS_TASK_COUNT    6'h2c
`define OFS_DONE_STAT     6'h30
// struct select fields
`define SEL_CH_LSB        0
`define SEL_ALT_BIT       5
// scatter-gather config fields
`define SG_CH_LSB         0
`define SG_PERIPH_BIT     8
// mode encodings
`define MODE_W            3
`define MODE_STOP         3'h0
`define MODE_BASIC        3'h1
`define MODE_AUTO         3'h2
`define MODE_PINGPONG     3'h3
`define MODE_MEM_SG       3'h4
`define MODE_PER_SG       3'h6
// item width encodings
`define ITEM_8            2'h0
`define ITEM_16           2'h1
`define ITEM_32           2'h2
`define SIZE_W            11
`define ASSIGN_RST        32'h00000000
`endif

// File: verilog/struct_mem.v
// small memory holding mode and remaining item count per control structure
`timescale 1ns/1ps
`default_nettype none
`include "dma_assign_regs.vh"
module struct_mem
(
    // clock
    input  wire                  clk,
    input  wire                  ce,
    // write port
    input  wire                  wr_en,
    input  wire [5:0]            wr_addr,
    input  wire [13:0]           wr_data,
    // read port
    input  wire [5:0]            rd_addr,
    output reg  [13:0]           rd_data
);
    reg [13:0] mem [0:63];

    // registered read; no reset so memory infers cleanly, software sets each structure first
    always @(posedge clk)
    begin
        if (ce)
        begin
            if (wr_en)
                mem[wr_addr] <= wr_data;
            rd_data <= mem[rd_addr];
        end
    end
endmodule
`default_nettype wire

// File: dv/dma_req_assign_sva.sv
// checker for the dma channel request/assign block, bound to its top module
`timescale 1ns/1ps
`default_nettype none
module dma_req_assign_sva
(
    // clock, reset and bus
    input wire logic        CLK,
    input wire logic        ARST_N,
    input wire logic        AVS_READ,
    input wire logic        AVS_WRITE,
    input wire logic        AVS_WAITREQUEST,
    input wire logic [31:0] AVS_READDATA,
    // completion, items and scatter-gather
    input wire logic [31:0] DEF_DONE_IRQ,
    input wire logic [31:0] SEC_DONE_IRQ,
    input wire logic        SW_DONE_IRQ,
    input wire logic        ITEM_VALID,
    input wire logic [1:0]  ITEM_WIDTH,
    input wire logic [9:0]  TASK_COUNT_OUT
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!ARST_N);
    // any bus request in flight
    wire req = AVS_READ | AVS_WRITE;
    a_wait_two_cycles: assert property (req && !$past(req) |-> AVS_WAITREQUEST ##1 AVS_WAITREQUEST ##1 !AVS_WAITREQUEST)
        else $error("bus answer latency wrong");
    a_idle_no_wait: assert property (!req |-> !AVS_WAITREQUEST)
        else $error("waitrequest while idle");
    a_sw_irq_pulse: assert property (SW_DONE_IRQ |=> !SW_DONE_IRQ)
        else $error("software completion longer than one cycle");
    a_sw_irq_own: assert property (SW_DONE_IRQ |-> !DEF_DONE_IRQ[30] && !SEC_DONE_IRQ[30])
        else $error("software completion on a peripheral line");
    a_irq_one_line: assert property ((DEF_DONE_IRQ & SEC_DONE_IRQ) == 32'h0)
        else $error("completion on both requester lines");
    a_def_irq_once: assert property (|DEF_DONE_IRQ |=> (DEF_DONE_IRQ & $past(DEF_DONE_IRQ)) == 32'h0)
        else $error("peripheral completion repeated");
    a_item_gap: assert property (ITEM_VALID |=> !ITEM_VALID)
        else $error("items closer than two cycles");
    a_item_width: assert property (ITEM_VALID |-> ITEM_WIDTH != 2'h3)
        else $error("item width not 8, 16 or 32");
    a_read_hold: assert property ($changed(AVS_READDATA) |-> $past(AVS_READ))
        else $error("read data changed without a read");
    a_count_on_write: assert property ($changed(TASK_COUNT_OUT) |-> $past(AVS_WRITE))
        else $error("task count changed without a write");
    c_sw_done: cover property (SW_DONE_IRQ);
    c_def_done: cover property (|DEF_DONE_IRQ);
    c_sec_done: cover property (|SEC_DONE_IRQ);
endmodule
bind dma_channel_request_assign dma_req_assign_sva chk
(
    .CLK(CLK), .ARST_N(ARST_N), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .AVS_READDATA(AVS_READDATA),
    .DEF_DONE_IRQ(DEF_DONE_IRQ), .SEC_DONE_IRQ(SEC_DONE_IRQ), .SW_DONE_IRQ(SW_DONE_IRQ),
    .ITEM_VALID(ITEM_VALID), .ITEM_WIDTH(ITEM_WIDTH), .TASK_COUNT_OUT(TASK_COUNT_OUT)
);
`default_nettype wire

// File: dv/periph_req_model.sv
// peripheral requester model: asks when armed, stops once served
`timescale 1ns/1ps
`default_nettype none
module periph_req_model
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        arst_n,
    // bench control
    input  wire logic [31:0] def_arm,
    input  wire logic [31:0] sec_arm,
    input  wire logic        slow,
    // completion lines from the block
    input  wire logic [31:0] def_done,
    input  wire logic [31:0] sec_done,
    // requests to the block
    output wire logic [31:0] def_req,
    output wire logic [31:0] sec_req
);
    logic [31:0] def_q1_reg, def_q2_reg, sec_q1_reg, sec_q2_reg, def_srv_reg, sec_srv_reg;
    // two-stage lag so the bench can pick a prompt or a slow requester
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            {def_q1_reg, def_q2_reg, sec_q1_reg, sec_q2_reg} <= 128'h0;
            {def_srv_reg, sec_srv_reg} <= 64'h0;
        end
        else
        begin
            def_q1_reg <= def_arm;
            def_q2_reg <= def_q1_reg;
            sec_q1_reg <= sec_arm;
            sec_q2_reg <= sec_q1_reg;
            // served on its own line, quiet until re-armed
            def_srv_reg <= (def_srv_reg | def_done) & def_arm;
            sec_srv_reg <= (sec_srv_reg | sec_done) & sec_arm;
        end
    end
    // no filtering here: the block must ignore the unassigned side
    assign def_req = (slow ? def_q2_reg : def_q1_reg) & ~def_srv_reg;
    assign sec_req = (slow ? sec_q2_reg : sec_q1_reg) & ~sec_srv_reg;
endmodule
`default_nettype wire

// File: dv/dma_channel_request_assign_tb.sv
// self-checking bench for the dma channel request/assign block
`timescale 1ns/1ps
`default_nettype none
`include "dma_assign_regs.vh"
module dma_channel_request_assign_tb;
    logic        CLK, ARST_N, AVS_READ, AVS_WRITE, AVS_WAITREQUEST, SW_DONE_IRQ, ITEM_VALID, SG_PERIPH_OUT, slow;
    logic [5:0]  AVS_ADDRESS;
    logic [31:0] AVS_WRITEDATA, AVS_READDATA, DEF_REQ, SEC_REQ, DEF_DONE_IRQ, SEC_DONE_IRQ, TASK_LIST_ADDR;
    logic [31:0] def_arm, sec_arm, def_seen, sec_seen, rd;
    logic [4:0]  ITEM_CHANNEL, last_ch;
    logic [1:0]  ITEM_WIDTH, last_w;
    logic [9:0]  TASK_COUNT_OUT;
    int          mismatches, cmp_count, items, sw_cnt, done_cnt, cycles;
    dma_channel_request_assign dut
    (
        .CLK(CLK), .ARST_N(ARST_N), .CE(1'b1), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
        .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(4'hf),
        .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .DEF_REQ(DEF_REQ), .SEC_REQ(SEC_REQ),
        .DEF_DONE_IRQ(DEF_DONE_IRQ), .SEC_DONE_IRQ(SEC_DONE_IRQ), .SW_DONE_IRQ(SW_DONE_IRQ),
        .ITEM_VALID(ITEM_VALID), .ITEM_CHANNEL(ITEM_CHANNEL), .ITEM_WIDTH(ITEM_WIDTH),
        .TASK_LIST_ADDR(TASK_LIST_ADDR), .TASK_COUNT_OUT(TASK_COUNT_OUT), .SG_PERIPH_OUT(SG_PERIPH_OUT)
    );
    periph_req_model peri
    (
        .clk(CLK), .arst_n(ARST_N), .def_arm(def_arm), .sec_arm(sec_arm), .slow(slow),
        .def_done(DEF_DONE_IRQ), .sec_done(SEC_DONE_IRQ), .def_req(DEF_REQ), .sec_req(SEC_REQ)
    );
    initial
    begin
        CLK = 1'b0;
        forever #2.5 CLK = ~CLK;
    end
    // sticky tallies; scenarios compare item deltas and cumulative totals, so nothing here is ever cleared
    always @(posedge CLK)
    begin
        cycles <= cycles + 1;
        if (ITEM_VALID)
        begin
            items   <= items + 1;
            last_w  <= ITEM_WIDTH;
            last_ch <= ITEM_CHANNEL;
        end
        sw_cnt   <= sw_cnt + SW_DONE_IRQ;
        done_cnt <= done_cnt + ((|DEF_DONE_IRQ) | (|SEC_DONE_IRQ));
        def_seen <= def_seen | DEF_DONE_IRQ;
        sec_seen <= sec_seen | SEC_DONE_IRQ;
        if (cycles == 30000)
        begin
            mismatches++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // one avalon cycle; waitrequest and read data are sampled on rising edges, release right after the answer edge
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
        @(posedge CLK);
        AVS_ADDRESS   <= a;
        AVS_WRITEDATA <= d;
        AVS_READ      <= !wr;
        AVS_WRITE     <= wr;
        do @(posedge CLK); while (AVS_WAITREQUEST !== 1'b0);
        rd = AVS_READDATA;
        AVS_READ  <= 1'b0;
        AVS_WRITE <= 1'b0;
    endtask
    task automatic rchk(input string nm, input logic [5:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(nm, exp, rd);
    endtask
    task automatic await(ref int v, input int n);
        for (int k = 0; k < 600 && v < n; k++) @(posedge CLK);
    endtask
    // structure memory has no reset, so mode and size go in before the enable
    task automatic setup(input logic [4:0] ch, input logic [31:0] n, input logic [1:0] w);
        bus(1'b1, `OFS_STRUCT_SEL, {27'h0, ch});
        bus(1'b1, `OFS_MODE, {29'h0, `MODE_BASIC});
        bus(1'b1, `OFS_SIZE, n);
        bus(1'b1, `OFS_ITEM_W, {30'h0, w});
        bus(1'b1, `OFS_CH_ENABLE, 32'h1 << ch);
    endtask
    task automatic t_reset();
        rchk("assign status", `OFS_ASSIGN_STAT, `ASSIGN_RST);
        rchk("enables", `OFS_CH_ENABLE, 32'h0);
        rchk("unmapped", 6'h3c, 32'h0);
    endtask
    task automatic t_sw();
        int base;
        for (int i = 0; i < 3; i++)
        begin
            base = items;
            setup(`SW_CHANNEL, i + 2, i[1:0]);
            bus(1'b1, `OFS_SW_REQ, 32'h1 << `SW_CHANNEL);
            await(sw_cnt, i + 1);
            chk("items", i + 2, items - base);
            chk("width", i, last_w);
            rchk("size", `OFS_SIZE, 32'h0);
            rchk("mode", `OFS_MODE, {29'h0, `MODE_STOP});
            rchk("enables", `OFS_CH_ENABLE, 32'h0);
        end
        chk("dedicated irq", 3, sw_cnt);
        chk("def irq", 32'h0, def_seen);
    endtask
    task automatic t_periph();
        int base;
        base = items;
        setup(5'h02, 32'h28, `ITEM_16);
        def_arm <= 32'h4;
        await(items, base + 5);
        def_arm <= 32'h0;
        repeat (6) @(posedge CLK);
        rchk("size partial", `OFS_SIZE, 32'h28 - (items - base));
        def_arm <= 32'h4;
        await(done_cnt, 1);
        chk("items", 32'h28, items - base);
        chk("def irq", 32'h4, def_seen);
        chk("dedicated irq", 3, sw_cnt);
        chk("channel", 32'h2, last_ch);
        rchk("done status", `OFS_DONE_STAT, 32'h40000004);
        bus(1'b1, `OFS_DONE_STAT, 32'h40000004);
        rchk("done cleared", `OFS_DONE_STAT, 32'h0);
        def_arm <= 32'h0;
        @(posedge CLK);
        base = items;
        def_arm <= 32'h4;
        repeat (30) @(posedge CLK);
        chk("items disabled", 0, items - base);
        def_arm <= 32'h0;
    endtask
    task automatic t_assign();
        int base;
        slow <= 1'b1;
        bus(1'b1, `OFS_SEC_ASSIGN, 32'h28);
        rchk("assign status", `OFS_ASSIGN_STAT, 32'h28);
        base = items;
        setup(5'h03, 32'h4, `ITEM_8);
        def_arm <= 32'h8;
        repeat (30) @(posedge CLK);
        chk("default blocked", 0, items - base);
        def_arm <= 32'h0;
        sec_arm <= 32'h8;
        await(done_cnt, 2);
        chk("sec irq", 32'h8, sec_seen);
        chk("channel", 32'h3, last_ch);
        chk("def irq", 32'h4, def_seen);
        bus(1'b1, `OFS_DEF_ASSIGN, 32'h8);
        rchk("assign status", `OFS_ASSIGN_STAT, 32'h20);
        sec_arm <= 32'h0;
    endtask
    task automatic t_sg();
        for (int f = 0; f < 2; f++)
        begin
            bus(1'b1, `OFS_SG_CFG, (f << `SG_PERIPH_BIT) | 32'h7);
            bus(1'b1, `OFS_TASK_LIST, 32'h20000100 + f);
            bus(1'b1, `OFS_TASK_COUNT, 32'h0c + f);
            @(posedge CLK);
            chk("sg flag", f, SG_PERIPH_OUT);
            chk("list", 32'h20000100 + f, TASK_LIST_ADDR);
            chk("count", 32'h0c + f, TASK_COUNT_OUT);
        end
    endtask
    initial
    begin
        {ARST_N, AVS_READ, AVS_WRITE, slow, AVS_ADDRESS} = 10'h0;
        {AVS_WRITEDATA, def_arm, sec_arm, def_seen, sec_seen} = 160'h0;
        {mismatches, cmp_count, items, sw_cnt, done_cnt, cycles} = 192'h0;
        repeat (6) @(posedge CLK);
        ARST_N <= 1'b1;
        t_reset();
        t_sw();
        t_periph();
        t_assign();
        t_sg();
        stop_test();
    end
endmodule
`default_nettype wire
